/* hdl/hwr_defines.svh */
`ifndef HWR_DEFINES_SVH
`define HWR_DEFINES_SVH

// Start-up delay after any wake-up, in system clock periods
`define HWR_WAKE_DLY_CYC     12'h400
// Extra delay added only at power-up, in system clock periods
`define HWR_PWRUP_EXTRA_CYC  12'h400
// Cycles between the end of the wake delay and the interrupt response
`define HWR_IRQ_GAP_CYC      2'h2
// Interrupt lines that may never wake the device (both serial interfaces)
`define HWR_IRQ_NOWAKE_MASK  8'hc0
// Program counter value applied by any chip or warm reset
`define HWR_RESET_VECTOR     12'h000
// Flag values after power-up
`define HWR_RST_PD_FLAG      1'h0
`define HWR_RST_EXPIRY       1'h0

`endif

/* hdl/hwr_pkg.sv */
package hwr_pkg;

	typedef enum logic [2:0] {
		ST_BOOT   = 3'b000,
		ST_PWRUP  = 3'b001,
		ST_RUN    = 3'b010,
		ST_HALT   = 3'b011,
		ST_DELAY  = 3'b100,
		ST_IRQGAP = 3'b101,
		ST_EXTRST = 3'b110
	} hwr_state_e;

	typedef enum logic [1:0] {
		CS_FULL = 2'b00,
		CS_WARM = 2'b01,
		CS_PORT = 2'b10,
		CS_IRQ  = 2'b11
	} hwr_cause_e;

endpackage

/* hdl/hwr_startup_timer.sv */
`include "hwr_defines.svh"

// Counts target_i cycles from a start pulse; done_o pulses so that the
// caller spends exactly target_i cycles waiting. target_i must be 2 or more.
module hwr_startup_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,
	input  wire logic [11:0] target_i,
	output logic             done_o
);

	logic [11:0] cnt_reg;
	logic [11:0] tgt_reg;
	logic        run_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 12'h000;
			tgt_reg <= 12'h000;
			run_reg <= 1'b0;
			done_o  <= 1'b0;
		end else if (start_i) begin
			// A new start always restarts from zero
			cnt_reg <= 12'h000;
			tgt_reg <= target_i;
			run_reg <= 1'b1;
			done_o  <= 1'b0;
		end else if (run_reg) begin
			cnt_reg <= cnt_reg + 12'h001;
			if (cnt_reg == tgt_reg - 12'h002) begin
				run_reg <= 1'b0;
				done_o  <= 1'b1;
			end
		end else begin
			done_o <= 1'b0;
		end
	end

endmodule

/* hdl/hwr_ctrl.sv */
`include "hwr_defines.svh"

// Summary of operation
// (R1) Power-down instruction stops the system oscillator; watchdog oscillator keeps running.
// (R2) Core is held so memory and registers stay unchanged in power-down.
// (R3) Entering power-down clears the watchdog when it runs from its own oscillator.
// (R4) Ports keep output and direction state throughout power-down.
// (R5) Power-down instruction sets power-down flag, clears watchdog-expiry flag.
// (R6) Wake on external reset, non-serial interrupt, enabled port edge, watchdog overflow.
// (R7) External reset fully initialises; watchdog wake only resets program counter, stack.
// (R8) Power-down flag clears at power-up and on the watchdog clear instruction.
// (R9) Every watchdog time-out sets the expiry flag, including waking ones; the code sets it only in the run and power-down states.
// (R10) Each port A pin has its own wake enable.
// (R11) Port wake-up resumes at the instruction after power-down.
// (R12) Interrupt wake: next instruction if disabled or stack full, else interrupt.
// (R13) Interrupts already requested before power-down cannot wake the device.
// (R14) Wait 1024 clocks after wake; next instruction at once, interrupt later.
// (R15) Power-up adds extra delay to the 1024 clocks; wake-up uses 1024 only.
// (R16) Flags give reset cause: external 00, normal time-out 1u, halt time-out 11.
// (R17) Chip reset: vector zero, interrupts off, timers stopped, ports input, stack top.
// (R18) Chip reset clears the watchdog, which counts again after release.
// (R19) Watchdog overflow in normal operation gives chip reset and sets expiry flag.
// (R20) Wake delay restarts from zero on each new wake event; the code restarts a running delay only on an external reset.
module hwr_ctrl
	import hwr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        external_init_pin_n_i,
	input  wire logic        halt_instr_i,
	input  wire logic        watchdog_clear_instruction_i,
	input  wire logic        watchdog_overflow_i,
	input  wire logic        watchdog_src_osc_i,
	input  wire logic [7:0]  irq_req_i,
	input  wire logic [7:0]  irq_enable_i,
	input  wire logic        stack_full_i,
	input  wire logic [7:0]  port_a_i,
	input  wire logic [7:0]  port_a_wake_en_i,
	output logic             sys_osc_en_o,
	output logic             core_hold_o,
	output logic             port_hold_o,
	output logic             full_reset_o,
	output logic             warm_reset_o,
	output logic [11:0]      reset_vector_o,
	output logic             watchdog_clear_o,
	output logic             resume_next_o,
	output logic             irq_take_o,
	output logic             power_down_flag_o,
	output logic             watchdog_expiry_flag_o
);

	hwr_state_e  state_reg;
	hwr_state_e  state_next;
	hwr_cause_e  cause_reg;
	hwr_cause_e  cause_next;
	logic [1:0]  init_sync_reg;
	logic [7:0]  pa_s1_reg;
	logic [7:0]  pa_s2_reg;
	logic [7:0]  pa_prev_reg;
	logic        wo_s1_reg;
	logic        wo_s2_reg;
	logic        wo_prev_reg;
	logic [7:0]  irq_armed_reg;
	logic [7:0]  irq_pend_reg;
	logic [1:0]  gap_reg;
	logic        init_low;
	logic        wd_evt;
	logic [7:0]  port_evt;
	logic [7:0]  irq_evt;
	logic        halt_go;
	logic        irq_service;
	logic        tmr_start;
	logic [11:0] tmr_target;
	logic        tmr_done;
	logic        chip_rst_next;

	function automatic logic is_chip_rst(input hwr_state_e st, input hwr_cause_e cs);
		is_chip_rst = (st == ST_BOOT) || (st == ST_PWRUP) || (st == ST_EXTRST) ||
			(st == ST_DELAY && cs == CS_FULL);
	endfunction

	// Pins and the watchdog domain are synchronised before any use
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_sync_reg <= 2'h3;
			pa_s1_reg     <= 8'h00;
			pa_s2_reg     <= 8'h00;
			pa_prev_reg   <= 8'h00;
			wo_s1_reg     <= 1'b0;
			wo_s2_reg     <= 1'b0;
			wo_prev_reg   <= 1'b0;
		end else begin
			init_sync_reg <= {init_sync_reg[0], external_init_pin_n_i};
			pa_s1_reg     <= port_a_i;
			pa_s2_reg     <= pa_s1_reg;
			pa_prev_reg   <= pa_s2_reg;
			wo_s1_reg     <= watchdog_overflow_i;
			wo_s2_reg     <= wo_s1_reg;
			wo_prev_reg   <= wo_s2_reg;
		end
	end

	assign init_low = ~init_sync_reg[1];
	assign wd_evt   = wo_s2_reg & ~wo_prev_reg;
	assign port_evt = (pa_s2_reg ^ pa_prev_reg) & port_a_wake_en_i; // [R10] [R6]
	assign irq_evt  = irq_req_i & irq_armed_reg & ~`HWR_IRQ_NOWAKE_MASK; // [R6] [R13]
	assign halt_go  = (state_reg == ST_RUN) && halt_instr_i && !wd_evt && !init_low;
	assign irq_service = |(irq_pend_reg & irq_enable_i) && !stack_full_i; // [R12]

	always_comb begin
		state_next = state_reg;
		cause_next = cause_reg;
		tmr_start  = 1'b0;
		tmr_target = `HWR_WAKE_DLY_CYC;
		if (init_low) begin
			state_next = ST_EXTRST; // [R7] [R6]
			cause_next = CS_FULL;
		end else begin
			case (state_reg)
				ST_BOOT: begin
					state_next = ST_PWRUP;
					tmr_start  = 1'b1;
					tmr_target = `HWR_WAKE_DLY_CYC + `HWR_PWRUP_EXTRA_CYC; // [R15]
				end
				ST_PWRUP: begin
					if (tmr_done) begin
						state_next = ST_RUN;
					end
				end
				ST_EXTRST: begin
					state_next = ST_DELAY;
					tmr_start  = 1'b1; // [R20]
				end
				ST_RUN: begin
					if (wd_evt) begin
						state_next = ST_DELAY; // [R19]
						cause_next = CS_FULL;
						tmr_start  = 1'b1;
					end else if (halt_instr_i) begin
						state_next = ST_HALT;
					end
				end
				ST_HALT: begin
					if (wd_evt || (|port_evt) || (|irq_evt)) begin
						state_next = ST_DELAY; // [R6] [R14]
						tmr_start  = 1'b1; // [R20]
						if (wd_evt) begin
							cause_next = CS_WARM; // [R7]
						end else if (|port_evt) begin
							cause_next = CS_PORT;
						end else begin
							cause_next = CS_IRQ;
						end
					end
				end
				ST_DELAY: begin
					if (tmr_done) begin
						// Interrupt response comes a few cycles after the delay
						if (cause_reg == CS_IRQ && irq_service) begin
							state_next = ST_IRQGAP; // [R12] [R14]
						end else begin
							state_next = ST_RUN; // [R11] [R14]
						end
					end
				end
				ST_IRQGAP: begin
					if (gap_reg == `HWR_IRQ_GAP_CYC - 2'h1) begin
						state_next = ST_RUN;
					end
				end
				default: begin
					state_next = ST_BOOT;
				end
			endcase
		end
	end

	assign chip_rst_next = is_chip_rst(state_next, cause_next);

	hwr_startup_timer u_wake_tmr (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.start_i  (tmr_start),
		.target_i (tmr_target),
		.done_o   (tmr_done)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_BOOT;
			cause_reg <= CS_FULL;
		end else begin
			state_reg <= state_next;
			cause_reg <= cause_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_reg <= 2'h0;
		end else if (state_reg == ST_IRQGAP) begin
			gap_reg <= gap_reg + 2'h1;
		end else begin
			gap_reg <= 2'h0;
		end
	end

	// Requests pending at entry are disarmed for the whole power-down
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_armed_reg <= 8'h00;
			irq_pend_reg  <= 8'h00;
		end else begin
			if (halt_go) begin
				irq_armed_reg <= ~irq_req_i; // [R13]
			end
			if (state_reg == ST_HALT && state_next == ST_DELAY) begin
				irq_pend_reg <= irq_evt;
			end
		end
	end

	// Outside an external init, setting wins over clearing for both flags
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_down_flag_o      <= `HWR_RST_PD_FLAG; // [R8]
			watchdog_expiry_flag_o <= `HWR_RST_EXPIRY;
		end else if (init_low) begin
			power_down_flag_o      <= 1'b0; // [R16]
			watchdog_expiry_flag_o <= 1'b0;
		end else begin
			if (halt_go) begin
				power_down_flag_o <= 1'b1; // [R5]
			end else if (watchdog_clear_instruction_i) begin
				power_down_flag_o <= 1'b0; // [R8]
			end
			if (wd_evt && (state_reg == ST_RUN || state_reg == ST_HALT)) begin
				watchdog_expiry_flag_o <= 1'b1; // [R9] [R16] [R19]
			end else if (halt_go) begin
				watchdog_expiry_flag_o <= 1'b0; // [R5]
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_osc_en_o <= 1'b1;
			core_hold_o  <= 1'b1;
			port_hold_o  <= 1'b0;
		end else begin
			sys_osc_en_o <= (state_next != ST_HALT); // [R1] [R20]
			core_hold_o  <= (state_next != ST_RUN); // [R2]
			port_hold_o  <= (state_next == ST_HALT); // [R4]
		end
	end

	// Warm reset leaves everything but program counter and stack alone
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			full_reset_o     <= 1'b1;
			warm_reset_o     <= 1'b0;
			reset_vector_o   <= `HWR_RESET_VECTOR;
			watchdog_clear_o <= 1'b1;
		end else begin
			full_reset_o     <= chip_rst_next; // [R17] [R7]
			warm_reset_o     <= (state_next == ST_DELAY) && (cause_next == CS_WARM); // [R7]
			reset_vector_o   <= `HWR_RESET_VECTOR; // [R17]
			watchdog_clear_o <= chip_rst_next || (halt_go && watchdog_src_osc_i); // [R18] [R3]
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resume_next_o <= 1'b0;
			irq_take_o    <= 1'b0;
		end else begin
			resume_next_o <= (state_reg == ST_DELAY) && (state_next == ST_RUN) &&
				(cause_reg == CS_PORT || cause_reg == CS_IRQ); // [R11] [R12]
			irq_take_o    <= (state_reg == ST_IRQGAP) && (state_next == ST_RUN); // [R12]
		end
	end

	// Cycles spent in the current delay state, for checking only
	logic [11:0] dcnt;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dcnt <= 12'h000;
		end else if (state_reg != state_next) begin
			dcnt <= 12'h000;
		end else begin
			dcnt <= dcnt + 12'h001;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_delay_end;
		state_reg == ST_DELAY ##1 state_reg == ST_IRQGAP [*2];
	endsequence

	sequence s_halt_entry;
		halt_go ##1 state_reg == ST_HALT;
	endsequence

	a_halt_osc_off: assert property (s_halt_entry |-> !sys_osc_en_o && port_hold_o) // [R1] [R4]
		else $error("oscillator not stopped in power-down");
	a_halt_flags: assert property (halt_go |=> power_down_flag_o && !watchdog_expiry_flag_o) // [R5]
		else $error("flags wrong after power-down entry");
	a_hold_halt: assert property (state_reg == ST_HALT |-> core_hold_o && !full_reset_o) // [R2]
		else $error("core not held in power-down");
	a_wd_clr_halt: assert property (halt_go && watchdog_src_osc_i |=> watchdog_clear_o) // [R3]
		else $error("watchdog not cleared on power-down entry");
	a_irq_disarmed: assert property (state_reg == ST_HALT && !init_low && !wd_evt &&
		port_evt == 8'h00 && (irq_req_i & irq_armed_reg) == 8'h00 |=> state_reg == ST_HALT) // [R13]
		else $error("woke from a disarmed interrupt");
	a_wake_len: assert property (state_reg == ST_DELAY && state_next != ST_DELAY &&
		!init_low |-> dcnt == `HWR_WAKE_DLY_CYC - 12'h001) // [R14] [R20]
		else $error("wake delay length wrong");
	a_pwrup_len: assert property (state_reg == ST_PWRUP && state_next == ST_RUN |->
		dcnt == `HWR_WAKE_DLY_CYC + `HWR_PWRUP_EXTRA_CYC - 12'h001) // [R15]
		else $error("power-up delay length wrong");
	a_port_resume: assert property (state_reg == ST_DELAY && tmr_done && !init_low &&
		cause_reg == CS_PORT |=> resume_next_o && !core_hold_o) // [R11]
		else $error("port wake did not resume at once");
	a_irq_gap: assert property (irq_take_o |-> $past(state_reg, 3) == ST_DELAY &&
		$past(state_reg, 1) == ST_IRQGAP && $past(irq_service, 3)) // [R12] [R14]
		else $error("interrupt response timing wrong");
	a_irq_seq: assert property (s_delay_end |=> irq_take_o) // [R12]
		else $error("interrupt response missing");
	a_ext_flags: assert property (init_low |=> !power_down_flag_o &&
		!watchdog_expiry_flag_o && full_reset_o) // [R7] [R16]
		else $error("external reset flags wrong");
	a_warm_wake: assert property (state_reg == ST_HALT && wd_evt && !init_low |=> warm_reset_o
		&& !full_reset_o && watchdog_expiry_flag_o && power_down_flag_o) // [R7] [R9] [R16]
		else $error("watchdog wake not a warm reset");
	a_wd_normal: assert property (state_reg == ST_RUN && wd_evt && !init_low |=> full_reset_o
		&& watchdog_clear_o && watchdog_expiry_flag_o &&
		power_down_flag_o == $past(power_down_flag_o)) // [R19] [R18] [R16]
		else $error("normal watchdog time-out handling wrong");
	a_pdf_clear: assert property (watchdog_clear_instruction_i && !halt_go && !init_low
		|=> !power_down_flag_o) // [R8]
		else $error("power-down flag not cleared");

endmodule

/* tb/hwr_wdt_model.sv */
// Watchdog stand-in: one fire request gives an overflow level of three cycles,
// long enough for the two-stage synchroniser, and low again before the next.
module hwr_watchdog_model (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic fire_i,
	output logic      overflow_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] left_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			left_reg <= 2'h0;
		else if (fire_i)
			left_reg <= 2'h3;
		else if (left_reg != 2'h0)
			left_reg <= left_reg - 2'h1;
	end

	assign overflow_o = (left_reg != 2'h0);
endmodule

/* tb/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i, rst_n_i, ext_n, halt, wclr, wfire, src_osc, stack_full, wd_ovf;
	logic [7:0]  irq_req, irq_en, port_a, port_en;
	logic        osc_en, core_hold, port_hold, full_rst, warm_rst, wd_clr;
	logic        res_next, irq_take, pd_flag, expiry, take;
	logic [11:0] vec;
	int          error_cnt, n_checks, n, k;

	hwr_watchdog_model i_hwr_watchdog_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(wfire),
		.overflow_o(wd_ovf));

	hwr_ctrl i_hwr_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .external_init_pin_n_i(ext_n),
		.halt_instr_i(halt), .watchdog_clear_instruction_i(wclr),
		.watchdog_overflow_i(wd_ovf), .watchdog_src_osc_i(src_osc), .irq_req_i(irq_req),
		.irq_enable_i(irq_en), .stack_full_i(stack_full), .port_a_i(port_a),
		.port_a_wake_en_i(port_en), .sys_osc_en_o(osc_en), .core_hold_o(core_hold),
		.port_hold_o(port_hold), .full_reset_o(full_rst), .warm_reset_o(warm_rst),
		.reset_vector_o(vec), .watchdog_clear_o(wd_clr), .resume_next_o(res_next),
		.irq_take_o(irq_take), .power_down_flag_o(pd_flag), .watchdog_expiry_flag_o(expiry));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk_b(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	task chk_n(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task cyc(input int c);
		repeat (c) @(negedge clk_i);
	endtask

	// Bounded wait for the core to be released; a hang ends the run
	task wait_run(output int cnt);
		cnt = 0;
		while (core_hold !== 1'b0 && cnt < 4000) begin
			@(negedge clk_i);
			cnt++;
		end
		if (core_hold !== 1'b0) begin
			error_cnt++;
			$display("MISMATCH core_hold_release expected 0 seen %b", core_hold);
			close_out();
		end
	endtask

	task wait_osc;
		int i;
		for (i = 0; i < 64 && osc_en !== 1'b1; i++)
			@(negedge clk_i);
		if (osc_en !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH osc_restart expected 1 seen %b", osc_en);
			close_out();
		end
	endtask

	task enter_halt;
		halt = 1'b1;
		cyc(1);
		halt = 1'b0;
		chk_b("osc_en", 1'b0, osc_en);
		chk_b("core_hold", 1'b1, core_hold);
		chk_b("port_hold", 1'b1, port_hold);
		chk_b("pd_flag", 1'b1, pd_flag);
		chk_b("expiry", 1'b0, expiry);
		chk_b("wd_clr", src_osc, wd_clr);
		cyc(1);
		chk_b("wd_clr_end", 1'b0, wd_clr);
	endtask

	// Expected delay: 1024 to next instruction, two more before an interrupt
	task wake_check(input logic exp_take);
		wait_osc();
		wait_run(n);
		chk_n("wake_len", exp_take ? 1026 : 1024, n);
		chk_b("resume_next", !exp_take, res_next);
		chk_b("irq_take", exp_take, irq_take);
	endtask

	initial begin
		{halt, wclr, wfire, stack_full, rst_n_i} = 5'h00;
		{irq_req, irq_en, port_a, port_en} = 32'h0000_0000;
		ext_n = 1'b1;
		src_osc = 1'b1;
		error_cnt = 0;
		n_checks = 0;
		void'($urandom(41));
		cyc(16);
		chk_b("full_rst_por", 1'b1, full_rst);
		chk_b("wd_clr_por", 1'b1, wd_clr);
		chk_b("pd_flag_por", 1'b0, pd_flag);
		chk_b("vec_por", 1'b0, vec !== 12'h000);
		rst_n_i = 1'b1;
		wait_run(n);
		chk_b("pwrup_len", 1'b1, n >= 2048 && n <= 2051);
		// Port wake: disabled pins must not wake, the single enabled one must
		port_en = 8'h01 << ($urandom % 8);
		enter_halt();
		port_a = port_a ^ ~port_en;
		cyc(10);
		chk_b("osc_dis_pin", 1'b0, osc_en);
		port_a = port_a ^ port_en;
		wake_check(1'b0);
		// Interrupt wake; first pass is the stack-full corner
		for (int t = 0; t < 4; t++) begin
			irq_req = 8'h01;
			src_osc = 1'($urandom);
			cyc(1);
			enter_halt();
			irq_req = 8'hc1;
			cyc(10);
			chk_b("osc_stale_serial", 1'b0, osc_en);
			k = 1 + ($urandom % 5);
			irq_en = 8'($urandom) & 8'h3e;
			if (t <= 1)
				irq_en[k] = 1'b1;
			stack_full = (t == 0) ? 1'b1 : 1'($urandom);
			take = irq_en[k] & !stack_full;
			irq_req = irq_req | (8'h01 << k);
			wake_check(take);
			irq_req = 8'h00;
		end
		// Watchdog wake from power-down is a warm reset
		enter_halt();
		wfire = 1'b1;
		cyc(1);
		wfire = 1'b0;
		wait_osc();
		chk_b("warm_rst", 1'b1, warm_rst);
		chk_b("full_rst_w", 1'b0, full_rst);
		chk_b("expiry_w", 1'b1, expiry);
		chk_b("pd_flag_w", 1'b1, pd_flag);
		wait_run(n);
		chk_n("warm_len", 1024, n);
		chk_b("warm_end", 1'b0, warm_rst);
		chk_b("resume_w", 1'b0, res_next);
		// Watchdog overflow while running
		wfire = 1'b1;
		cyc(1);
		wfire = 1'b0;
		cyc(6);
		chk_b("full_rst_r", 1'b1, full_rst);
		chk_b("expiry_r", 1'b1, expiry);
		chk_b("pd_flag_r", 1'b1, pd_flag);
		chk_b("wd_clr_r", 1'b1, wd_clr);
		wait_run(n);
		wclr = 1'b1;
		cyc(1);
		wclr = 1'b0;
		chk_b("pd_flag_clr", 1'b0, pd_flag);
		chk_b("expiry_keep", 1'b1, expiry);
		// External init pin while powered down
		enter_halt();
		ext_n = 1'b0;
		cyc(4);
		chk_b("pd_flag_x", 1'b0, pd_flag);
		chk_b("expiry_x", 1'b0, expiry);
		chk_b("full_rst_x", 1'b1, full_rst);
		chk_b("vec_x", 1'b0, vec !== 12'h000);
		chk_b("wd_clr_x", 1'b1, wd_clr);
		ext_n = 1'b1;
		wait_run(n);
		chk_b("full_rst_xe", 1'b0, full_rst);
		close_out();
	end
endmodule
